// file: design/isam_status.sv
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Contract
// - In master transmit the ack flag takes the slave acknowledge bit, 1 for NACK, at its end.
// - The transmit-active flag sets when a master byte starts and clears at the slave acknowledge.
// - A collision during master operation sets a flag that stays until software clears it.
// - The general call flag sets on a general call address and clears on Stop.
// - The ten-bit match flag sets on a matching second address byte and clears on Stop.
// - A transmit write while busy is dropped and sets a flag only software clears.
// - A byte arriving while the receive buffer is still full sets a software-cleared overflow flag.
// - In slave mode the data flag clears on own address match and sets on a data byte.
// - On Start, Repeated Start or Stop exactly the latest condition flag reads 1.
// - After a slave address byte the direction flag is 1 for read and 0 for write.
// - The receive-full flag sets when the buffer is loaded and clears when software reads it.
// - The transmit-full flag sets on a software write and clears when that data is sent.
// - An address bit whose mask bit is 1 matches either value.
// - An address bit whose mask bit is 0 must equal the stored address bit.
// - A control bit chooses a 10-bit or 7-bit own address and compare.
module isam_status (
	input wire logic aclk, // System clock, 25 MHz.
	input wire logic aresetn, // Synchronous reset, active low.
	input wire logic [isam_pkg::ISAM_ADDR_W-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output logic s_axi_wready, // Write data ready.
	output logic [1:0] s_axi_bresp, // Write response.
	output logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [isam_pkg::ISAM_ADDR_W-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output logic s_axi_arready, // Read address ready.
	output logic [31:0] s_axi_rdata, // Read data.
	output logic [1:0] s_axi_rresp, // Read response.
	output logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	input wire logic ev_start, // Start or Repeated Start seen, pulse.
	input wire logic ev_stop, // Stop seen, pulse.
	input wire logic ev_mtx_begin, // Master byte transmission begins, pulse.
	input wire logic ev_mtx_ack, // Slave acknowledge bit ended, pulse.
	input wire logic ack_nack, // Acknowledge value, 1 is NACK.
	input wire logic ev_collision, // Bus collision in master operation, pulse.
	input wire logic ev_addr, // Slave address reception complete, pulse.
	input wire logic [isam_pkg::ISAM_ADR_W-1:0] in_addr, // Received address.
	input wire logic in_ten, // Received address in 10-bit form.
	input wire logic in_rw, // Received direction, 1 is read.
	input wire logic ev_data, // Slave data byte received, pulse.
	input wire logic ev_rx_byte, // Shift register byte complete, pulse.
	input wire logic [7:0] rx_byte, // Byte from the shift register.
	input wire logic ev_tx_done, // Transmit data fully sent, pulse.
	input wire logic engine_busy, // Bus engine busy, level.
	output logic [7:0] tx_holding_register, // Byte for the engine to send.
	output logic tx_holding_full, // Transmit byte waiting.
	output logic slave_hit, // Own address matched, pulse.
	output logic general_call_out, // General call accepted, pulse.
	output logic irq // Interrupt, level, high.
);
	import isam_pkg::*;

	typedef struct packed {
		logic [15:0] stat;
		logic [ISAM_ADR_W-1:0] mask;
		logic [ISAM_ADR_W-1:0] own;
		logic wide;
		logic gcen;
		logic [7:0] txb;
		logic [7:0] rxb;
		logic [ISAM_IRQ_W-1:0] ists;
		logic [ISAM_IRQ_W-1:0] imsk;
		logic irq;
		logic awr;
		logic [ISAM_ADDR_W-1:0] awa;
		logic awh;
		logic wr;
		logic [31:0] wd;
		logic [3:0] ws;
		logic wh;
		logic bv;
		logic [1:0] br;
		logic arr;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic hit;
		logic gcall;
	} isam_state_t;

	isam_state_t state_q;
	isam_state_t state_d;
	logic addr_hit;
	logic wr_fire;
	logic rd_fire;
	logic tx_write;
	logic gc_hit;
	logic [15:0] wmask;

	// Registers live only on aligned words below the end of the map.
	function automatic logic isam_mapped(input logic [ISAM_ADDR_W-1:0] a);
		return (a[1:0] == 2'b00) && (a <= ISAM_OFF_IRQ_MASK);
	endfunction

	isam_addr_match u_match (
		.in_addr(in_addr),
		.in_ten(in_ten),
		.own_addr(state_q.own),
		.addr_mask(state_q.mask),
		.wide_sel(state_q.wide),
		.hit(addr_hit)
	);

	assign wr_fire = state_q.awh & state_q.wh & ~state_q.bv;
	assign rd_fire = s_axi_arvalid & state_q.arr;
	assign tx_write = wr_fire & (state_q.awa == ISAM_OFF_TX) & state_q.ws[0];
	assign gc_hit = state_q.gcen & ~in_ten & (in_addr[ISAM_NARROW_W-1:0] == ISAM_GC_ADDR);
	assign wmask = {{8{state_q.ws[1]}}, {8{state_q.ws[0]}}};

	always_comb begin
		state_d = state_q;
		state_d.hit = 1'b0;
		state_d.gcall = 1'b0;

		// Write channel capture, each side independent.
		if (s_axi_awvalid && state_q.awr) begin
			state_d.awh = 1'b1;
			state_d.awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && state_q.wr) begin
			state_d.wh = 1'b1;
			state_d.wd = s_axi_wdata;
			state_d.ws = s_axi_wstrb;
		end
		if (state_q.bv && s_axi_bready) begin
			state_d.bv = 1'b0;
		end

		// Software writes come first so hardware sets below override them.
		if (wr_fire) begin
			state_d.awh = 1'b0;
			state_d.wh = 1'b0;
			state_d.bv = 1'b1;
			state_d.br = isam_mapped(state_q.awa) ? ISAM_RESP_OKAY : ISAM_RESP_SLVERR;
			unique case (state_q.awa)
				ISAM_OFF_STATUS: begin
					state_d.stat = state_q.stat & ~(ISAM_ST_CLR_ONLY & wmask & ~state_q.wd[15:0]);
				end
				ISAM_OFF_MASK: begin
					state_d.mask = (state_q.mask & ~wmask[9:0]) | (state_q.wd[9:0] & wmask[9:0]);
				end
				ISAM_OFF_OWN: begin
					state_d.own = (state_q.own & ~wmask[9:0]) | (state_q.wd[9:0] & wmask[9:0]);
				end
				ISAM_OFF_CTRL: begin
					if (state_q.ws[0]) begin
						state_d.wide = state_q.wd[ISAM_CTRL_WIDE];
						state_d.gcen = state_q.wd[ISAM_CTRL_GCEN];
					end
				end
				ISAM_OFF_TX: begin
					if (state_q.ws[0]) begin
						if (engine_busy || state_q.stat[ISAM_ST_TXF]) begin
							state_d.stat[ISAM_ST_WCOL] = 1'b1;
							state_d.ists[ISAM_IRQ_WCOL] = 1'b1;
						end else begin
							state_d.txb = state_q.wd[7:0];
							state_d.stat[ISAM_ST_TXF] = 1'b1;
						end
					end
				end
				ISAM_OFF_IRQ_MASK: begin
					if (state_q.ws[0]) begin
						state_d.imsk = state_q.wd[ISAM_IRQ_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Read channel; side effects act on the read that is taken.
		if (state_q.rv && s_axi_rready) begin
			state_d.rv = 1'b0;
		end
		if (rd_fire) begin
			state_d.rv = 1'b1;
			state_d.rr = isam_mapped(s_axi_araddr) ? ISAM_RESP_OKAY : ISAM_RESP_SLVERR;
			state_d.rd = 32'h0000_0000;
			unique case (s_axi_araddr)
				ISAM_OFF_STATUS: state_d.rd[15:0] = state_q.stat;
				ISAM_OFF_MASK: state_d.rd[9:0] = state_q.mask;
				ISAM_OFF_OWN: state_d.rd[9:0] = state_q.own;
				ISAM_OFF_CTRL: begin
					state_d.rd[ISAM_CTRL_WIDE] = state_q.wide;
					state_d.rd[ISAM_CTRL_GCEN] = state_q.gcen;
				end
				ISAM_OFF_TX: state_d.rd[7:0] = state_q.txb;
				ISAM_OFF_RX: begin
					state_d.rd[7:0] = state_q.rxb;
					state_d.stat[ISAM_ST_RXF] = 1'b0;
				end
				ISAM_OFF_IRQ_STAT: begin
					state_d.rd[ISAM_IRQ_W-1:0] = state_q.ists;
					state_d.ists = '0;
				end
				ISAM_OFF_IRQ_MASK: state_d.rd[ISAM_IRQ_W-1:0] = state_q.imsk;
				default: begin
				end
			endcase
		end

		// Hardware events; applied last so a hardware set beats a same-cycle software or read clear.
		// set wins over clear, except a same-cycle ack clears MTX, a same-cycle stop clears START and a same-cycle tx done clears TXF set by a write.
		if (ev_start) begin
			state_d.stat[ISAM_ST_START] = 1'b1;
			state_d.stat[ISAM_ST_STOP] = 1'b0;
		end
		if (ev_stop) begin
			state_d.stat[ISAM_ST_STOP] = 1'b1;
			state_d.stat[ISAM_ST_START] = 1'b0;
			state_d.stat[ISAM_ST_GC] = 1'b0;
			state_d.stat[ISAM_ST_TEN] = 1'b0;
			state_d.ists[ISAM_IRQ_STOP] = 1'b1;
		end
		if (ev_mtx_begin) begin
			state_d.stat[ISAM_ST_MTX] = 1'b1;
		end
		if (ev_mtx_ack) begin
			state_d.stat[ISAM_ST_ACK] = ack_nack;
			state_d.stat[ISAM_ST_MTX] = 1'b0;
		end
		if (ev_collision) begin
			state_d.stat[ISAM_ST_BCL] = 1'b1;
			state_d.ists[ISAM_IRQ_BCL] = 1'b1;
		end
		if (ev_addr && gc_hit) begin
			state_d.stat[ISAM_ST_GC] = 1'b1;
			state_d.gcall = 1'b1;
			state_d.stat[ISAM_ST_DA] = 1'b0;
			state_d.stat[ISAM_ST_RW] = in_rw;
		end
		if (ev_addr && addr_hit) begin
			state_d.stat[ISAM_ST_DA] = 1'b0;
			state_d.stat[ISAM_ST_RW] = in_rw;
			state_d.stat[ISAM_ST_TEN] = in_ten;
			state_d.hit = 1'b1;
			state_d.ists[ISAM_IRQ_MATCH] = 1'b1;
		end
		if (ev_data) begin
			state_d.stat[ISAM_ST_DA] = 1'b1;
		end
		if (ev_rx_byte) begin
			if (state_d.stat[ISAM_ST_RXF]) begin
				state_d.stat[ISAM_ST_OVF] = 1'b1;
				state_d.ists[ISAM_IRQ_OVF] = 1'b1;
			end else begin
				state_d.rxb = rx_byte;
				state_d.stat[ISAM_ST_RXF] = 1'b1;
				state_d.ists[ISAM_IRQ_RX] = 1'b1;
			end
		end
		if (ev_tx_done) begin
			state_d.stat[ISAM_ST_TXF] = 1'b0;
			state_d.ists[ISAM_IRQ_TXDONE] = 1'b1;
		end

		state_d.awr = ~state_d.awh & ~state_d.bv;
		state_d.wr = ~state_d.wh & ~state_d.bv;
		state_d.arr = ~state_d.rv;
		state_d.irq = |(state_d.ists & state_d.imsk);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= '0;
			state_q.stat <= ISAM_ST_RESET;
			state_q.mask <= ISAM_MASK_RESET;
			state_q.own <= ISAM_OWN_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	assign s_axi_awready = state_q.awr;
	assign s_axi_wready = state_q.wr;
	assign s_axi_bvalid = state_q.bv;
	assign s_axi_bresp = state_q.br;
	assign s_axi_arready = state_q.arr;
	assign s_axi_rvalid = state_q.rv;
	assign s_axi_rdata = state_q.rd;
	assign s_axi_rresp = state_q.rr;
	assign tx_holding_register = state_q.txb;
	assign tx_holding_full = state_q.stat[ISAM_ST_TXF];
	assign slave_hit = state_q.hit;
	assign general_call_out = state_q.gcall;
	assign irq = state_q.irq;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence tx_accepted_s;
		tx_write && !engine_busy && !state_q.stat[ISAM_ST_TXF];
	endsequence
	sequence tx_sent_s;
		ev_tx_done && !tx_write;
	endsequence

	ack_latch_a: assert property (ev_mtx_ack |=> state_q.stat[ISAM_ST_ACK] == $past(ack_nack))
		else $error("ack flag does not follow acknowledge");
	mtx_window_a: assert property ((ev_mtx_begin && !ev_mtx_ack) ##1 !ev_mtx_ack [*2]
		|-> state_q.stat[ISAM_ST_MTX])
		else $error("transmit active flag dropped early");
	mtx_end_a: assert property (ev_mtx_ack && !ev_mtx_begin |=> !state_q.stat[ISAM_ST_MTX])
		else $error("transmit active flag not cleared at ack");
	coll_sticky_a: assert property (ev_collision |=> state_q.stat[ISAM_ST_BCL]
		##1 (state_q.stat[ISAM_ST_BCL] || $past(wr_fire && state_q.awa == ISAM_OFF_STATUS)))
		else $error("collision flag lost without a clear");
	gc_set_a: assert property (ev_addr && gc_hit && !ev_stop |=> state_q.stat[ISAM_ST_GC])
		else $error("general call flag not set");
	stop_clear_a: assert property (ev_stop && !ev_addr |=> !state_q.stat[ISAM_ST_GC]
		&& !state_q.stat[ISAM_ST_TEN] && state_q.stat[ISAM_ST_STOP])
		else $error("stop did not clear match flags");
	ten_match_a: assert property (ev_addr && addr_hit && in_ten && !ev_stop
		|=> state_q.stat[ISAM_ST_TEN] && slave_hit)
		else $error("ten-bit match not flagged");
	wcol_drop_a: assert property (tx_write && engine_busy
		|=> state_q.stat[ISAM_ST_WCOL] && $stable(tx_holding_register))
		else $error("busy write was not refused");
	ovf_keep_a: assert property (ev_rx_byte && state_q.stat[ISAM_ST_RXF] && !rd_fire
		|=> state_q.stat[ISAM_ST_OVF] && $stable(state_q.rxb))
		else $error("overflow not flagged or byte overwritten");
	da_addr_a: assert property (ev_addr && addr_hit && !ev_data
		|=> !state_q.stat[ISAM_ST_DA] && state_q.stat[ISAM_ST_RW] == $past(in_rw))
		else $error("address byte flags wrong");
	cond_excl_a: assert property ((ev_start || ev_stop) |=>
		state_q.stat[ISAM_ST_START] != state_q.stat[ISAM_ST_STOP])
		else $error("start and stop flags not exclusive");
	rx_load_a: assert property (ev_rx_byte && !state_q.stat[ISAM_ST_RXF]
		|=> state_q.stat[ISAM_ST_RXF] && state_q.rxb == $past(rx_byte))
		else $error("receive buffer not loaded");
	tx_cycle_a: assert property (tx_holding_full ##1 tx_sent_s |=> !tx_holding_full)
		else $error("transmit full not cleared after send");
	tx_fill_a: assert property (tx_accepted_s |=> tx_holding_full)
		else $error("transmit full not set on write");
	mask_any_a: assert property (ev_addr && !in_ten && !state_q.wide
		&& ((in_addr[6:0] ^ state_q.own[6:0]) & ~state_q.mask[6:0]) == 7'h00
		|=> slave_hit)
		else $error("masked address compare wrong");
	write_resp_a: assert property (wr_fire |=> s_axi_bvalid && !s_axi_awready)
		else $error("write response missing");
endmodule // isam_status

// file: common/isam_pkg.sv
package isam_pkg;
	// Register map, byte addresses on the AXI4-Lite port.
	localparam int ISAM_ADDR_W = 6;
	localparam logic [5:0] ISAM_OFF_STATUS = 6'h00;
	localparam logic [5:0] ISAM_OFF_MASK = 6'h04;
	localparam logic [5:0] ISAM_OFF_OWN = 6'h08;
	localparam logic [5:0] ISAM_OFF_CTRL = 6'h0c;
	localparam logic [5:0] ISAM_OFF_TX = 6'h10;
	localparam logic [5:0] ISAM_OFF_RX = 6'h14;
	localparam logic [5:0] ISAM_OFF_IRQ_STAT = 6'h18;
	localparam logic [5:0] ISAM_OFF_IRQ_MASK = 6'h1c;

	// Bus status field positions.
	localparam int ISAM_ST_ACK = 15;
	localparam int ISAM_ST_MTX = 14;
	localparam int ISAM_ST_BCL = 10;
	localparam int ISAM_ST_GC = 9;
	localparam int ISAM_ST_TEN = 8;
	localparam int ISAM_ST_WCOL = 7;
	localparam int ISAM_ST_OVF = 6;
	localparam int ISAM_ST_DA = 5;
	localparam int ISAM_ST_STOP = 4;
	localparam int ISAM_ST_START = 3;
	localparam int ISAM_ST_RW = 2;
	localparam int ISAM_ST_RXF = 1;
	localparam int ISAM_ST_TXF = 0;
	localparam logic [15:0] ISAM_ST_CLR_ONLY = 16'h04d8;
	localparam logic [15:0] ISAM_ST_RESET = 16'h0000;

	// Control register fields.
	localparam int ISAM_CTRL_WIDE = 0;
	localparam int ISAM_CTRL_GCEN = 1;

	// Interrupt status and mask field positions.
	localparam int ISAM_IRQ_W = 7;
	localparam int ISAM_IRQ_BCL = 0;
	localparam int ISAM_IRQ_WCOL = 1;
	localparam int ISAM_IRQ_OVF = 2;
	localparam int ISAM_IRQ_RX = 3;
	localparam int ISAM_IRQ_TXDONE = 4;
	localparam int ISAM_IRQ_STOP = 5;
	localparam int ISAM_IRQ_MATCH = 6;

	localparam int ISAM_ADR_W = 10;
	localparam int ISAM_NARROW_W = 7;
	localparam logic [6:0] ISAM_GC_ADDR = 7'h00;
	localparam logic [9:0] ISAM_MASK_RESET = 10'h000;
	localparam logic [9:0] ISAM_OWN_RESET = 10'h000;

	localparam logic [1:0] ISAM_RESP_OKAY = 2'b00;
	localparam logic [1:0] ISAM_RESP_SLVERR = 2'b10;
endpackage

// file: design/isam_addr_match.sv
`timescale 1ns/10ps
module isam_addr_match (
	input wire logic [isam_pkg::ISAM_ADR_W-1:0] in_addr, // Incoming slave address.
	input wire logic in_ten, // Incoming address used the 10-bit form.
	input wire logic [isam_pkg::ISAM_ADR_W-1:0] own_addr, // Own slave address.
	input wire logic [isam_pkg::ISAM_ADR_W-1:0] addr_mask, // Mask, 1 ignores the bit.
	input wire logic wide_sel, // Own address is 10 bits wide.
	output logic hit // Masked compare matched.
);
	import isam_pkg::*;

	logic [ISAM_ADR_W-1:0] bit_ok;

	genvar i;
	generate
		for (i = 0; i < ISAM_ADR_W; i++) begin : g_bit
			if (i < ISAM_NARROW_W) begin : g_lo
				// masked bits pass. unmasked must equal.
				assign bit_ok[i] = addr_mask[i] | (in_addr[i] == own_addr[i]);
			end else begin : g_hi
				// upper bits ignored in narrow mode.
				assign bit_ok[i] = ~wide_sel | addr_mask[i] | (in_addr[i] == own_addr[i]);
			end
		end
	endgenerate

	// address form must match the width setting.
	assign hit = (in_ten == wide_sel) & (&bit_ok);
endmodule // isam_addr_match

// file: test/isam_bus_model.sv
`timescale 1ns/10ps
// Stand-in for the bus engine: one-cycle event pulses with the values that travel with them.
module isam_bus_model (
	input wire logic aclk, // Clock.
	output logic [8:0] ev, // Start, stop, mtx begin, mtx ack, collision, addr, data, rx, tx done.
	output logic ack_nack, // Acknowledge value, 1 is NACK.
	output logic [9:0] in_addr, // Received address.
	output logic in_ten, // Address in 10-bit form.
	output logic in_rw, // Direction, 1 is read.
	output logic [7:0] rx_byte, // Received byte.
	output logic engine_busy // Engine busy level.
);
	initial begin
		ev = 9'h000;
		{ack_nack, in_ten, in_rw, engine_busy} = 4'h0;
		in_addr = 10'h000;
		rx_byte = 8'h00;
	end
	task automatic fire(input logic [8:0] sel, input logic [9:0] a = 10'h000,
		input logic t = 1'b0, input logic r = 1'b0, input logic [7:0] b = 8'h00);
		@(posedge aclk);
		ev <= sel;
		in_addr <= a;
		in_ten <= t;
		in_rw <= r;
		ack_nack <= r;
		rx_byte <= b;
		@(posedge aclk);
		ev <= 9'h000;
		// Qualifiers mean nothing outside their pulse, so they are scrambled afterwards.
		in_addr <= ~a;
		in_ten <= ~t;
		in_rw <= ~r;
		ack_nack <= ~r;
		rx_byte <= ~b;
	endtask
endmodule // isam_bus_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
	import isam_pkg::*;
	localparam logic [8:0] E_START = 9'h100;
	localparam logic [8:0] E_STOP = 9'h080;
	localparam logic [8:0] E_MTXB = 9'h040;
	localparam logic [8:0] E_MTXA = 9'h020;
	localparam logic [8:0] E_COL = 9'h010;
	localparam logic [8:0] E_ADDR = 9'h008;
	localparam logic [8:0] E_DATA = 9'h004;
	localparam logic [8:0] E_RX = 9'h002;
	localparam logic [8:0] E_TXD = 9'h001;
	localparam logic [1:0] OK = ISAM_RESP_OKAY;
	localparam logic [1:0] SE = ISAM_RESP_SLVERR;
	typedef struct packed {
		logic [1:0] ctrl;
		logic [9:0] own;
		logic [9:0] msk;
		logic [9:0] adr;
		logic ten;
		logic rw;
		logic hit;
	} isam_row_t;
	isam_row_t rows [9] = '{
		'{2'h0, 10'h02a, 10'h000, 10'h02a, 1'b0, 1'b1, 1'b1},
		'{2'h0, 10'h02a, 10'h000, 10'h02b, 1'b0, 1'b0, 1'b0},
		'{2'h0, 10'h02a, 10'h001, 10'h02b, 1'b0, 1'b1, 1'b1},
		'{2'h0, 10'h02a, 10'h040, 10'h06a, 1'b0, 1'b0, 1'b1},
		'{2'h1, 10'h3a5, 10'h000, 10'h3a5, 1'b1, 1'b1, 1'b1},
		'{2'h1, 10'h3a5, 10'h200, 10'h1a5, 1'b1, 1'b0, 1'b1},
		'{2'h1, 10'h3a5, 10'h0ff, 10'h1a5, 1'b1, 1'b1, 1'b0},
		'{2'h0, 10'h02a, 10'h000, 10'h02a, 1'b1, 1'b1, 1'b0},
		'{2'h1, 10'h02a, 10'h000, 10'h02a, 1'b0, 1'b1, 1'b0}};
	logic aclk, aresetn;
	logic [5:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [8:0] ev;
	logic ack_nack, in_ten, in_rw, engine_busy;
	logic [9:0] in_addr;
	logic [7:0] rx_byte, tx_holding_register;
	logic tx_holding_full, slave_hit, general_call_out, irq;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	isam_bus_model u_eng (.aclk, .ev, .ack_nack, .in_addr, .in_ten, .in_rw, .rx_byte,
		.engine_busy);
	isam_status u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ev_start(ev[8]), .ev_stop(ev[7]),
		.ev_mtx_begin(ev[6]), .ev_mtx_ack(ev[5]), .ack_nack, .ev_collision(ev[4]),
		.ev_addr(ev[3]), .in_addr, .in_ten, .in_rw, .ev_data(ev[2]), .ev_rx_byte(ev[1]),
		.rx_byte, .ev_tx_done(ev[0]), .engine_busy, .tx_holding_register, .tx_holding_full,
		.slave_hit, .general_call_out, .irq);

	task automatic end_of_test();
		if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er = OK);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask

	task automatic rchk(input string nm, input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er = OK);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(nm, e, s_axi_rdata & m);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask

	task automatic st(input logic [31:0] m, input logic [31:0] e);
		rchk("status", ISAM_OFF_STATUS, m, e);
	endtask

	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end

	// Hang guard, far above the few hundred cycles the sequence needs.
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			end_of_test();
		end
	end

	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 6'h00;
		s_axi_araddr = 6'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (5) @(posedge aclk);
		chk("readies", 32'h0, {s_axi_awready, s_axi_wready, s_axi_arready, irq});
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) rchk("reset value", 6'(i * 4), 32'hffffffff, 32'h0);
		rchk("unmapped", 6'h20, 32'hffffffff, 32'h0, SE);
		rchk("unaligned", 6'h02, 32'hffffffff, 32'h0, SE);
		wr(6'h24, 32'h1, SE);
		foreach (rows[i]) begin
			wr(ISAM_OFF_CTRL, 32'(rows[i].ctrl));
			wr(ISAM_OFF_OWN, 32'(rows[i].own));
			wr(ISAM_OFF_MASK, 32'hfffffc00 | 32'(rows[i].msk));
			rchk("mask", ISAM_OFF_MASK, 32'hffffffff, 32'(rows[i].msk));
			u_eng.fire(E_STOP);
			u_eng.fire(E_ADDR, rows[i].adr, rows[i].ten, rows[i].rw);
			@(negedge aclk);
			chk("slave_hit", 32'(rows[i].hit), 32'(slave_hit));
			st(rows[i].hit ? 32'h134 : 32'h130, {23'h0, rows[i].hit & rows[i].ten, 3'h0,
				2'b10, rows[i].hit & rows[i].rw, 2'h0});
		end
		u_eng.fire(E_START);
		st(32'h18, 32'h08);
		u_eng.fire(E_START | E_STOP);
		st(32'h18, 32'h10);
		wr(ISAM_OFF_STATUS, 32'hffff);
		st(32'h18, 32'h10);
		wr(ISAM_OFF_STATUS, 32'h0);
		st(32'hffffffff, 32'h0);
		u_eng.fire(E_MTXB);
		st(32'hc000, 32'h4000);
		u_eng.fire(E_MTXA, 10'h0, 1'b0, 1'b1);
		st(32'hc000, 32'h8000);
		u_eng.fire(E_MTXB);
		u_eng.fire(E_MTXA, 10'h0, 1'b0, 1'b0);
		st(32'hc000, 32'h0);
		wr(ISAM_OFF_IRQ_MASK, 32'h1 << ISAM_IRQ_BCL);
		u_eng.fire(E_COL);
		st(32'h400, 32'h400);
		chk("irq", 32'h1, 32'(irq));
		rchk("irq status", ISAM_OFF_IRQ_STAT, 32'h1, 32'h1);
		rchk("irq status", ISAM_OFF_IRQ_STAT, 32'h1, 32'h0);
		chk("irq", 32'h0, 32'(irq));
		wr(ISAM_OFF_IRQ_MASK, 32'h0);
		u_eng.fire(E_COL);
		st(32'h400, 32'h400);
		chk("irq masked", 32'h0, 32'(irq));
		wr(ISAM_OFF_STATUS, 32'hfbff);
		st(32'h400, 32'h0);
		wr(ISAM_OFF_TX, 32'h5a);
		chk("tx full", 32'h1, 32'(tx_holding_full));
		wr(ISAM_OFF_TX, 32'ha5);
		st(32'h81, 32'h81);
		chk("tx byte", 32'h5a, 32'(tx_holding_register));
		u_eng.fire(E_TXD);
		st(32'h1, 32'h0);
		wr(ISAM_OFF_STATUS, 32'h0);
		u_eng.engine_busy <= 1'b1;
		wr(ISAM_OFF_TX, 32'h33);
		st(32'h81, 32'h80);
		rchk("tx byte", ISAM_OFF_TX, 32'hffffffff, 32'h5a);
		u_eng.engine_busy <= 1'b0;
		u_eng.fire(E_RX, 10'h0, 1'b0, 1'b0, 8'h11);
		st(32'h42, 32'h02);
		u_eng.fire(E_RX, 10'h0, 1'b0, 1'b0, 8'h22);
		st(32'h42, 32'h42);
		rchk("rx byte", ISAM_OFF_RX, 32'hffffffff, 32'h11);
		st(32'h42, 32'h40);
		wr(ISAM_OFF_CTRL, 32'h2);
		u_eng.fire(E_ADDR, 10'h000, 1'b0, 1'b1);
		@(negedge aclk);
		chk("general call", 32'h1, 32'(general_call_out));
		st(32'h324, 32'h204);
		u_eng.fire(E_DATA);
		st(32'h20, 32'h20);
		u_eng.fire(E_STOP);
		st(32'h200, 32'h0);
		rchk("irq status", ISAM_OFF_IRQ_STAT, 32'h7f, 32'h3f);
		end_of_test();
	end
endmodule // testbench
